// ==== rtl/cdr_consts.svh ====
// Purpose: constants for the clock recovery control block
// Assumes: byte registers on a plain strobe port
// Notes: offsets are register indices on the local port
//
// Notes on behaviour
// - drift limit fraction set by two bits
// - detector lock window from two-bit field
// - idle bit times reset clock recovery
// - fast phase alignment when enable set
// - bit zero picks PLL or FFT detector
// - discrete rate loads oversample code from ROM
// - eight-bit loop filter coefficient, upper four bits drive loop
// - command 0X02 at 0X00 starts transmit
// - data rate by code or 16-bit word
// - on-off keying follows each data bit
// - 1010 correlation then immediate phase fix
// - idle timeout returns to wait, or to held without fast phase lock
`ifndef CDR_CONSTS_SVH
`define CDR_CONSTS_SVH
`define CDR_OFS_CMD       8'h00
`define CDR_OFS_OPT_A     8'h1F
`define CDR_OFS_OPT_B     8'h20
`define CDR_OFS_COEFF     8'h2C
`define CDR_OFS_RATE_SEL  8'h30
`define CDR_OFS_RATE_LO   8'h31
`define CDR_OFS_RATE_HI   8'h32
`define CDR_OFS_STATUS    8'h33
`define CDR_CMD_TX        8'h02
`define CDR_CMD_IDLE      8'h01
`define CDR_RST_OPT_A     8'h00
`define CDR_RST_OPT_B     8'h80
`define CDR_RST_COEFF     8'h00
`define CDR_RST_RATE      16'h0100
`define CDR_HOLD_BIT      7
`define CDR_OSR_MSB       3
`define CDR_PHASE_BITS    16
`define CDR_PATTERN       4'hA
`define CDR_IDLE_LONG     5'd16
`define CDR_IDLE_MID      5'd8
`define CDR_IDLE_SHORT    5'd4
`endif

// ==== rtl/cdr_ctrl.sv ====
// Purpose: clock recovery loop control and transmit command
// Assumes: rx_data_i synchronous, one sample per clock enable
// Notes: oversample tick from a divider set by oversample_rate
`timescale 1ns/1ps
`include "cdr_consts.svh"
module cdr_ctrl
  import cdr_pkg::*;
#(
  parameter int PHASE_BITS = `CDR_PHASE_BITS
)(
  input  wire logic       clk_i,        // 10 MHz clock
  input  wire logic       reset_i,      // async reset, high
  input  wire logic [7:0] addr_i,       // register index
  input  wire logic [7:0] wdata_i,      // write data
  input  wire logic       wr_i,         // write strobe
  input  wire logic       rd_i,         // read strobe
  input  wire logic       rx_data_i,    // sliced receive bit
  input  wire logic       tx_data_i,    // transmit data bit
  output logic      [7:0] rdata_o,      // read data, next cycle
  output logic            rec_clk_o,    // recovered bit clock
  output logic            rec_data_o,   // recovered data
  output logic            pll_det_o,    // PLL detector chosen
  output logic      [1:0] win_limit_o,  // detector lock window
  output logic            tx_active_o,  // transmit operation
  output logic            pa_on_o       // output driver enable
);

  // elaboration check: a narrower accumulator cannot hold the rate word
  // step with useful resolution, a wider one buys nothing
  if (PHASE_BITS < 12 || PHASE_BITS > 24)
  begin : g_bad_phase_bits
    $error("PHASE_BITS out of range");
  end

  cdr_opt_a_s       opt_a_q, opt_a_d;
  cdr_opt_b_s       opt_b_q, opt_b_d;
  logic       [7:0] coeff_q, coeff_d;
  logic       [3:0] rate_sel_q, rate_sel_d;
  logic      [15:0] rate_q, rate_d;
  logic             tx_q, tx_d;
  logic       [7:0] rdata_q, rdata_d;
  // loop state and recovered bit, read back through the status register
  cdr_state_e       state_q, state_d;
  logic             rec_data_q, rec_data_d;

  // ROM: oversample code for each discrete rate selector
  function automatic logic [3:0] osr_rom(input logic [3:0] sel);
    logic [3:0] r;
    r = 4'hB - ((sel > 4'hB) ? 4'hB : sel);
    return r;
  endfunction

  // drift limit as a right shift of the nominal step
  function automatic logic [2:0] drift_shift(input logic [1:0] f);
    return 3'h3 + {1'b0, f};
  endfunction

  // register writes and reads
  // reads answer one cycle later through rdata_q and fall back to zero,
  // so the command register and unmapped indices always read as zero;
  // a rate selector write also reloads oversample_rate from the ROM
  always_comb
  begin
    opt_a_d    = opt_a_q;
    opt_b_d    = opt_b_q;
    coeff_d    = coeff_q;
    rate_sel_d = rate_sel_q;
    rate_d     = rate_q;
    tx_d       = tx_q;
    rdata_d    = 8'h00;
    if (wr_i)
    begin
      unique case (addr_i)
        `CDR_OFS_CMD:
        begin
          if (wdata_i == `CDR_CMD_TX)
            tx_d = 1'b1;
          else if (wdata_i == `CDR_CMD_IDLE)
            tx_d = 1'b0;
        end
        `CDR_OFS_OPT_A: opt_a_d = cdr_opt_a_s'(wdata_i);
        `CDR_OFS_OPT_B:
        begin
          opt_b_d = cdr_opt_b_s'(wdata_i);
          opt_b_d.unused = 3'h0;
        end
        `CDR_OFS_COEFF: coeff_d = wdata_i;
        `CDR_OFS_RATE_SEL:
        begin
          rate_sel_d = wdata_i[3:0];
          opt_b_d.oversample_rate = osr_rom(wdata_i[3:0]);
        end
        `CDR_OFS_RATE_LO: rate_d[7:0] = wdata_i;
        `CDR_OFS_RATE_HI: rate_d[15:8] = wdata_i;
        default: ;
      endcase
    end
    if (rd_i)
    begin
      unique case (addr_i)
        `CDR_OFS_OPT_A:    rdata_d = opt_a_q;
        `CDR_OFS_OPT_B:    rdata_d = opt_b_q;
        `CDR_OFS_COEFF:    rdata_d = coeff_q;
        `CDR_OFS_RATE_SEL: rdata_d = {4'h0, rate_sel_q};
        `CDR_OFS_RATE_LO:  rdata_d = rate_q[7:0];
        `CDR_OFS_RATE_HI:  rdata_d = rate_q[15:8];
        `CDR_OFS_STATUS:   rdata_d = {4'h0, state_q, tx_q, rec_data_q};
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      opt_a_q    <= cdr_opt_a_s'(`CDR_RST_OPT_A);
      opt_b_q    <= cdr_opt_b_s'(`CDR_RST_OPT_B);
      coeff_q    <= `CDR_RST_COEFF;
      rate_sel_q <= 4'h0;
      rate_q     <= `CDR_RST_RATE;
      tx_q       <= 1'b0;
      rdata_q    <= 8'h00;
    end
    else
    begin
      opt_a_q    <= opt_a_d;
      opt_b_q    <= opt_b_d;
      coeff_q    <= coeff_d;
      rate_sel_q <= rate_sel_d;
      rate_q     <= rate_d;
      tx_q       <= tx_d;
      rdata_q    <= rdata_d;
    end
  end

  // oversample divider: code n ticks every 2**(11-n) clocks, codes above 11 every clock
  logic [11:0] os_cnt_q, os_cnt_d;
  logic        os_tick;
  logic [11:0] os_mask;
  assign os_mask = 12'((13'h1 << (4'hB - ((opt_b_q.oversample_rate > 4'hB)
                   ? 4'hB : opt_b_q.oversample_rate))) - 13'h1);
  assign os_tick = (os_cnt_q & os_mask) == 12'h000;

  always_comb
  begin
    os_cnt_d = os_cnt_q + 12'h001;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      os_cnt_q <= 12'h000;
    else
      os_cnt_q <= os_cnt_d;
  end

  // digital loop: phase accumulator with clamped step
  // the step starts at the rate word and is nudged on each input
  // transition; the clamp lets it pass the drift limit by at most one nudge so noise
  // between packets cannot walk the recovered clock away
  logic [PHASE_BITS-1:0]    phase_q, phase_d;
  logic [15:0]              step_q, step_d;
  logic [15:0]              step_nom, step_lim;
  logic signed [8:0]        integ_q, integ_d;
  logic [4:0]               idle_q, idle_d;
  logic [4:0]               idle_max;
  logic                     prev_q, prev_d;
  logic [3:0]               shreg_q, shreg_d;
  logic                     rec_clk_q, rec_clk_d;

  assign step_nom = rate_q;
  assign step_lim = step_nom >> drift_shift(opt_a_q.rate_drift_limit);

  // idle limit in bit times; zero turns the activity check off
  // idle is counted at phase wraps, so the limit is in whole bit times
  always_comb
  begin
    unique case (opt_a_q.idle_watch)
      2'b11: idle_max = `CDR_IDLE_LONG;
      2'b10: idle_max = `CDR_IDLE_MID;
      2'b01: idle_max = `CDR_IDLE_SHORT;
      2'b00: idle_max = 5'd0;
    endcase
  end

  // loop next state
  // hold overrides every state at the bottom, so a hold write always
  // lands in the held state on the second edge after the write strobe

  always_comb
  begin
    state_d    = state_q;
    phase_d    = phase_q;
    step_d     = step_q;
    integ_d    = integ_q;
    idle_d     = idle_q;
    prev_d     = prev_q;
    shreg_d    = shreg_q;
    rec_data_d = rec_data_q;
    rec_clk_d  = rec_clk_q;
    unique case (state_q)
      CDR_HELD:
      begin
        phase_d    = '0;
        step_d     = step_nom;
        integ_d    = '0;
        idle_d     = '0;
        // outputs of the loop stay quiet while it is held
        rec_clk_d  = 1'b0;
        rec_data_d = 1'b0;
        if (!opt_b_q.recovery_hold)
          state_d = opt_a_q.quick_phase_lock_en ? CDR_WAIT : CDR_TRACK;
      end
      CDR_WAIT:
      begin
        if (os_tick)
        begin
          prev_d = rx_data_i;
          if (rx_data_i != prev_q)
          begin
            shreg_d = {shreg_q[2:0], rx_data_i};
            if ({shreg_q[2:0], rx_data_i} == `CDR_PATTERN)
            begin
              phase_d = PHASE_BITS'(1) << (PHASE_BITS - 1);
              state_d = CDR_TRACK;
            end
          end
        end
      end
      CDR_TRACK:
      begin
        if (os_tick)
        begin
          phase_d = phase_q + PHASE_BITS'(step_q);
          integ_d = integ_q + (rx_data_i ? 9'sd1 : -9'sd1);
          prev_d  = rx_data_i;
          if (rx_data_i != prev_q)
          begin
            idle_d = '0;
            if (phase_q[PHASE_BITS-1] && step_q > step_nom - step_lim)
              step_d = step_q - {12'h000, coeff_q[7:4]} - 16'h1;
            else if (!phase_q[PHASE_BITS-1] && step_q < step_nom + step_lim)
              step_d = step_q + {12'h000, coeff_q[7:4]} + 16'h1;
          end
          if (phase_d < phase_q)
          begin
            rec_data_d = !integ_q[8];
            integ_d    = '0;
            if (rx_data_i == prev_q)
              idle_d = idle_q + 5'd1;
          end
          rec_clk_d = phase_d[PHASE_BITS-1];
          if (idle_max != 5'd0 && idle_q >= idle_max)
          begin
            idle_d  = '0;
            shreg_d = '0;
            state_d = opt_a_q.quick_phase_lock_en ? CDR_WAIT : CDR_HELD;
          end
        end
      end
      default: state_d = CDR_HELD;
    endcase
    if (opt_b_q.recovery_hold)
      state_d = CDR_HELD;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q    <= CDR_HELD;
      phase_q    <= '0;
      step_q     <= `CDR_RST_RATE;
      integ_q    <= '0;
      idle_q     <= '0;
      prev_q     <= 1'b0;
      shreg_q    <= 4'h0;
      rec_data_q <= 1'b0;
      rec_clk_q  <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      phase_q    <= phase_d;
      step_q     <= step_d;
      integ_q    <= integ_d;
      idle_q     <= idle_d;
      prev_q     <= prev_d;
      shreg_q    <= shreg_d;
      rec_data_q <= rec_data_d;
      rec_clk_q  <= rec_clk_d;
    end
  end

  // registered outputs; detector choice and window passed on
  // one cycle later than the option register, so every top output
  // comes straight from a flip-flop
  logic       pll_q, pa_q;
  logic [1:0] win_q;
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pll_q <= 1'b0;
      win_q <= 2'b00;
      pa_q  <= 1'b0;
    end
    else
    begin
      pll_q <= opt_a_q.fsk_detector_select;
      win_q <= opt_a_q.detector_window_limit;
      pa_q  <= tx_q & tx_data_i;
    end
  end

  assign rdata_o     = rdata_q;
  assign rec_clk_o   = rec_clk_q;
  assign rec_data_o  = rec_data_q;
  assign pll_det_o   = pll_q;
  assign win_limit_o = win_q;
  assign tx_active_o = tx_q;
  assign pa_on_o     = pa_q;
endmodule

// ==== rtl/cdr_pkg.sv ====
// Purpose: types for the clock recovery control block
// Assumes: constants live in cdr_consts.svh
// Notes: option register fields as packed structs
package cdr_pkg;
  typedef struct packed {
    logic [1:0] rate_drift_limit;
    logic [1:0] detector_window_limit;
    logic [1:0] idle_watch;
    logic       quick_phase_lock_en;
    logic       fsk_detector_select;
  } cdr_opt_a_s;

  typedef struct packed {
    logic       recovery_hold;
    logic [2:0] unused;
    logic [3:0] oversample_rate;
  } cdr_opt_b_s;

  typedef enum logic [1:0] {
    CDR_HELD    = 2'b00,
    CDR_WAIT    = 2'b01,
    CDR_TRACK   = 2'b10
  } cdr_state_e;
endpackage

// ==== tb/cdr_ctrl_properties.sv ====
// Purpose: port checks for the clock recovery control block
// Assumes: one clock, registers reached by one-cycle strobes
// Notes: shadow registers follow writes, never the design state
`timescale 1ns/1ps
`include "cdr_consts.svh"
module cdr_ctrl_properties #(
  parameter int PHASE_BITS = 16
)(
  input wire logic       clk_i,       // clock
  input wire logic       reset_i,     // async reset
  input wire logic [7:0] addr_i,      // register index
  input wire logic [7:0] wdata_i,     // write data
  input wire logic       wr_i,        // write strobe
  input wire logic       rd_i,        // read strobe
  input wire logic       tx_data_i,   // transmit bit
  input wire logic [7:0] rdata_o,     // read data
  input wire logic       rec_clk_o,   // recovered clock
  input wire logic       pll_det_o,   // detector choice
  input wire logic [1:0] win_limit_o, // lock window
  input wire logic       tx_active_o, // transmit state
  input wire logic       pa_on_o      // driver enable
);
  logic [7:0] opt_a_q, opt_a_d, coeff_q, coeff_d;
  logic       hold_q, hold_d;
  // shadow next values, taken from the strobe alone
  always_comb
  begin
    opt_a_d = (wr_i && addr_i == `CDR_OFS_OPT_A) ? wdata_i : opt_a_q;
    coeff_d = (wr_i && addr_i == `CDR_OFS_COEFF) ? wdata_i : coeff_q;
    hold_d  = (wr_i && addr_i == `CDR_OFS_OPT_B) ? wdata_i[7] : hold_q;
  end
  // shadow registers; hold comes out of reset set
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      opt_a_q <= `CDR_RST_OPT_A;
      coeff_q <= `CDR_RST_COEFF;
      hold_q  <= 1'b1;
    end
    else
    begin
      opt_a_q <= opt_a_d;
      coeff_q <= coeff_d;
      hold_q  <= hold_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_tx_enter: assert property (
    wr_i && addr_i == `CDR_OFS_CMD && wdata_i == `CDR_CMD_TX |=> tx_active_o)
    else $error("transmit not entered");
  chk_tx_leave: assert property (
    wr_i && addr_i == `CDR_OFS_CMD && wdata_i == `CDR_CMD_IDLE
    |=> !tx_active_o) else $error("transmit not left");
  chk_cmd_wronly: assert property (
    rd_i && addr_i == `CDR_OFS_CMD |=> rdata_o == 8'h00)
    else $error("command register read back");
  chk_pa_follows: assert property (
    1'b1 |=> pa_on_o == ($past(tx_active_o) && $past(tx_data_i)))
    else $error("driver does not follow data bit");
  chk_det_pick: assert property (
    wr_i && addr_i == `CDR_OFS_OPT_A |-> ##2 pll_det_o == $past(wdata_i[0], 2))
    else $error("detector choice wrong");
  chk_win_pick: assert property (
    wr_i && addr_i == `CDR_OFS_OPT_A
    |-> ##2 win_limit_o == $past(wdata_i[5:4], 2))
    else $error("lock window wrong");
  chk_opt_back: assert property (
    rd_i && addr_i == `CDR_OFS_OPT_A |=> rdata_o == $past(opt_a_q))
    else $error("options readback wrong");
  chk_coeff_back: assert property (
    rd_i && addr_i == `CDR_OFS_COEFF |=> rdata_o == $past(coeff_q))
    else $error("coefficient readback wrong");
  chk_hold_quiet: assert property (
    hold_q && $past(hold_q) && $past(hold_q, 2) |-> !rec_clk_o)
    else $error("recovered clock runs while held");
endmodule
bind cdr_ctrl cdr_ctrl_properties #(.PHASE_BITS(PHASE_BITS)) u_props (
  .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .tx_data_i(tx_data_i), .rdata_o(rdata_o),
  .rec_clk_o(rec_clk_o), .pll_det_o(pll_det_o), .win_limit_o(win_limit_o),
  .tx_active_o(tx_active_o), .pa_on_o(pa_on_o));

// ==== tb/cdr_rx_source.sv ====
// Purpose: far-side bit source for the clock recovery block
// Assumes: the receive line is a sliced level, one value a bit time
// Notes: holds its level while off, seen as no activity
`timescale 1ns/1ps
module cdr_rx_source #(
  parameter int BIT_CLKS = 16
)(
  input  wire logic clk_i,   // clock
  input  wire logic reset_i, // async reset
  input  wire logic run_i,   // send alternating bits
  output logic      rx_o     // sliced bit to the block
);
  int cnt_q;
  // alternating run, as long as run_i stays up
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt_q <= 0;
      rx_o  <= 1'b0;
    end
    else if (run_i)
    begin
      cnt_q <= (cnt_q == BIT_CLKS - 1) ? 0 : cnt_q + 1;
      if (cnt_q == BIT_CLKS - 1)
        rx_o <= !rx_o;
    end
  end
endmodule

// ==== tb/test_clock_data_recovery_control.sv ====
// Purpose: self-checking bench for clock recovery control
// Assumes: 10 MHz clock, strobes one cycle, read data a cycle later
// Notes: rate word 0x1000 makes a bit time 16 clocks
`timescale 1ns/1ps
`include "cdr_consts.svh"
module test_clock_data_recovery_control;
  logic       clk_i, reset_i, wr_i, rd_i, tx_data_i, run, rx;
  logic [7:0] addr_i, wdata_i, rdata_o, d;
  logic       rec_clk_o, rec_data_o, pll_det_o, tx_active_o, pa_on_o;
  logic [1:0] win_limit_o;
  int         fail_count = 0;
  int         total_checks = 0;
  cdr_ctrl u_cdr_ctrl (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rx_data_i(rx),
    .tx_data_i(tx_data_i), .rdata_o(rdata_o), .rec_clk_o(rec_clk_o),
    .rec_data_o(rec_data_o), .pll_det_o(pll_det_o),
    .win_limit_o(win_limit_o), .tx_active_o(tx_active_o),
    .pa_on_o(pa_on_o));
  cdr_rx_source u_cdr_rx_source (.clk_i(clk_i), .reset_i(reset_i),
    .run_i(run), .rx_o(rx));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  task automatic end_of_test;
  begin
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // bus write: strobe one cycle beside address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
  begin
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  end
  endtask
  // bus read: data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
  begin
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
  begin
    rd(a);
    check(d, e);
  end
  endtask
  // polls status until the recovery state shows up, bounded
  task automatic wait_state(input logic [1:0] st);
  begin
    rd(`CDR_OFS_STATUS);
    for (int k = 0; k < 200 && d[3:2] !== st; k++)
      rd(`CDR_OFS_STATUS);
    check({6'h00, d[3:2]}, {6'h00, st});
  end
  endtask
  task automatic t_reset;
  begin
    rd_chk(`CDR_OFS_OPT_A, `CDR_RST_OPT_A);
    rd_chk(`CDR_OFS_OPT_B, `CDR_RST_OPT_B);
    rd_chk(`CDR_OFS_COEFF, `CDR_RST_COEFF);
    rd_chk(`CDR_OFS_CMD, 8'h00);
    rd_chk(8'h05, 8'h00);
  end
  endtask
  // each two-bit field walks all four codes across the loop
  task automatic t_opt_a;
    logic [7:0] v;
  begin
    for (int i = 0; i < 4; i++)
    begin
      v = 8'({8'hE4, 8'hE4} >> (2 * i));
      wr(`CDR_OFS_OPT_A, v);
      rd_chk(`CDR_OFS_OPT_A, v);
      check({7'h00, pll_det_o}, {7'h00, v[0]});
      check({6'h00, win_limit_o}, {6'h00, v[5:4]});
    end
  end
  endtask
  task automatic t_rate;
  begin
    wr(`CDR_OFS_OPT_B, 8'hFF);
    rd_chk(`CDR_OFS_OPT_B, 8'h8F);
    foreach (d[i])
      if (i == 3 || i == 7 || i == 0)
      begin
        wr(`CDR_OFS_RATE_SEL, 8'((i == 7) ? 11 : i));
        rd_chk(`CDR_OFS_OPT_B, 8'h80 | 8'(11 - ((i == 7) ? 11 : i)));
      end
    wr(`CDR_OFS_COEFF, 8'hA5);
    rd_chk(`CDR_OFS_COEFF, 8'hA5);
  end
  endtask
  task automatic t_tx;
  begin
    // rate, options and coefficient were all set before the command
    wr(`CDR_OFS_CMD, `CDR_CMD_TX);
    tx_data_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    check({7'h00, tx_active_o}, 8'h01);
    check({7'h00, pa_on_o}, 8'h01);
    @(posedge clk_i);
    tx_data_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check({7'h00, pa_on_o}, 8'h00);
    wr(`CDR_OFS_CMD, `CDR_CMD_IDLE);
    @(posedge clk_i);
    #1;
    check({7'h00, tx_active_o}, 8'h00);
  end
  endtask
  task automatic t_recover;
  begin
    wr(`CDR_OFS_RATE_HI, 8'h10);
    wr(`CDR_OFS_RATE_LO, 8'h00);
    wr(`CDR_OFS_OPT_A, 8'h06);
    // a tick each clock gives 16 samples per bit, well under 400
    wr(`CDR_OFS_OPT_B, 8'h0B);
    wait_state(2'd1);
    run <= 1'b1;
    wait_state(2'd2);
    run <= 1'b0;
    wait_state(2'd1);
    wr(`CDR_OFS_OPT_A, 8'h00);
    wr(`CDR_OFS_OPT_B, 8'h8B);
    wait_state(2'd0);
    check({7'h00, rec_data_o}, 8'h00);
    wr(`CDR_OFS_OPT_B, 8'h0B);
    wait_state(2'd2);
    repeat (300) @(posedge clk_i);
    wait_state(2'd2);
  end
  endtask
  // clock, reset for three cycles, then the scenarios
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial
  begin
    {reset_i, wr_i, rd_i, tx_data_i, run} = 5'b10000;
    {addr_i, wdata_i} = 16'h0000;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_opt_a();
    t_rate();
    t_tx();
    t_recover();
    end_of_test();
  end
  // watchdog at 30000 cycles, well beyond the few hundred cycles the run needs
  initial
  begin
    #(100 * 30000);
    fail_count++;
    end_of_test();
  end
endmodule
